// File: verilog/eep_slave.sv
// Functional notes
// - Write cycle starts at STOP; bus disabled, SDA released, address ignored.
// - Master makes clock, START and STOP; device is only a target.
// - SDA is open drain: pull low or release, never drive high.
// - Protect low: all writable; high: one quarter protected, or the whole array with EEP_PROT_ALL.
// - Protected: ack address bytes, nack first protected data byte, no write.
// - Unconnected strap inputs read as zero; eight devices per bus.
// - SDA change while SCL high is START or STOP, never data.
// - START is SDA falling with SCL high; nothing happens before one.
// - STOP is SDA rising with SCL high; master ends each operation so.
// - Slave address: upper nibble 1010, next three bits match straps.
// - Address byte LSB: 1 selects read, 0 selects write.
// - Matching address is acknowledged; mismatch gets no acknowledge.
// - Receiver acknowledges by holding SDA low in the ninth clock.
// - In write mode every received byte outside the protected area is acknowledged.
// - Read: shift 8 bits, release, sample ack; nack ends, wait STOP.
// - STOP after a write starts programming; requests ignored until done.
// - Page write buffers up to 64 bytes, programmed in one cycle.
// - Each accepted data byte increments only the six low address bits.
// - Beyond 64 bytes the page address wraps and overwrites earlier bytes.
// - Polling: address with write bit nacked while busy, acked after.
// - Address counter holds last address plus one; reads wrap 8191 to 0, writes wrap within the page.
`timescale 1ns/1ps
`include "eep_consts.svh"

module eep_slave #(
    parameter int WR_CYCLES = `EEP_WR_CYCLES,
    parameter int PU_CYCLES = `EEP_PU_CYCLES,
    parameter eep_pkg::eep_prot_t PROT_MODE = eep_pkg::EEP_PROT_LOW_QTR
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic scl,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    input wire logic write_protect,
    input wire logic device_select_bit0,
    input wire logic device_select_bit1,
    input wire logic device_select_bit2,
    output logic busy
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [5:0] sync_s;
    logic scl_s, sda_s, wp_s;
    logic [2:0] strap_s;
    logic scl_q_ff, sda_q_ff;
    logic start_ev, stop_ev, scl_rise, scl_fall;
    eep_pkg::eep_state_t state_ff;
    logic [3:0] bit_cnt_ff;
    logic [7:0] shift_ff;
    logic [7:0] tx_ff;
    logic ack_ff, mack_ff, sda_low_ff, pend_ff;
    logic [`EEP_ADDR_W-1:0] addr_ff;
    logic busy_ff, pwr_ok_ff;
    logic [19:0] timer_ff;
    logic [17:0] pwr_cnt_ff;
    logic [7:0] mem [0:`EEP_MEM_BYTES-1];
    logic [7:0] page_buf [0:`EEP_PAGE_BYTES-1];
    logic [`EEP_PAGE_BYTES-1:0] buf_vld_ff;
    logic [`EEP_ADDR_W-`EEP_PAGE_W-1:0] page_ff;
    logic [6:0] commit_ff;
    logic byte_end, dev_match, wr_open, byte_ok, prog_go, prot_hit;
    logic [7:0] rd_byte;

    // Straps rely on pad pull-downs so a floating pin reads zero
    eep_sync #(.W(6)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .din({device_select_bit2, device_select_bit1, device_select_bit0,
              write_protect, sda_in, scl}),
        .dout(sync_s)
    );

    assign scl_s = sync_s[0];
    assign sda_s = sync_s[1];
    assign wp_s = sync_s[2];
    assign strap_s = sync_s[5:3];

    // ****************************************
    // Protection decode
    // ****************************************
    function automatic logic is_prot(input logic [`EEP_ADDR_W-1:0] a,
                                     input logic wp);
        logic hit;
        hit = 1'b0;
        case (PROT_MODE)
            eep_pkg::EEP_PROT_LOW_QTR: hit = (a[12:11] == 2'h0);
            eep_pkg::EEP_PROT_HIGH_QTR: hit = (a[12:11] == 2'h3);
            eep_pkg::EEP_PROT_ALL: hit = 1'b1;
            default: hit = 1'b0;
        endcase
        return hit & wp;
    endfunction

    // ****************************************
    // Bus condition detection
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            scl_q_ff <= 1'b1;
            sda_q_ff <= 1'b1;
        end else begin
            scl_q_ff <= scl_s;
            sda_q_ff <= sda_s;
        end
    end

    // SDA moving while SCL is high is never data
    assign start_ev = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
    assign stop_ev = scl_s & scl_q_ff & ~sda_q_ff & sda_s;
    assign scl_rise = scl_s & ~scl_q_ff;
    assign scl_fall = ~scl_s & scl_q_ff;

    assign byte_end = scl_fall & ~ack_ff & (bit_cnt_ff == 4'h8);
    assign dev_match = (shift_ff[7:1] == {`EEP_DEV_CODE, strap_s});
    assign prot_hit = is_prot(addr_ff, wp_s);
    assign wr_open = byte_end & (state_ff == eep_pkg::EEP_DEVADDR) &
                     dev_match & ~shift_ff[0];
    assign byte_ok = byte_end & (state_ff == eep_pkg::EEP_WDATA) & ~prot_hit;
    assign prog_go = stop_ev & pend_ff & ~busy_ff;
    assign rd_byte = mem[addr_ff];

    // ****************************************
    // Power-up hold-off
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pwr_cnt_ff <= 18'h0_0000;
            pwr_ok_ff <= 1'b0;
        end else if (!pwr_ok_ff) begin
            if (pwr_cnt_ff == 18'(PU_CYCLES - 1)) begin
                pwr_ok_ff <= 1'b1;
            end
            pwr_cnt_ff <= pwr_cnt_ff + 18'h0_0001;
        end
    end

    // ****************************************
    // Protocol engine
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            state_ff <= eep_pkg::EEP_IDLE;
            bit_cnt_ff <= 4'h0;
            shift_ff <= 8'h00;
            tx_ff <= 8'h00;
            ack_ff <= 1'b0;
            mack_ff <= 1'b0;
            sda_low_ff <= 1'b0;
            pend_ff <= 1'b0;
            addr_ff <= 13'h0000;
        end else if (start_ev) begin
            bit_cnt_ff <= 4'h0;
            ack_ff <= 1'b0;
            sda_low_ff <= 1'b0;
            if (!busy_ff && pwr_ok_ff) begin
                state_ff <= eep_pkg::EEP_DEVADDR;
            end else begin
                state_ff <= eep_pkg::EEP_IDLE;
            end
        end else if (stop_ev) begin
            state_ff <= eep_pkg::EEP_IDLE;
            bit_cnt_ff <= 4'h0;
            ack_ff <= 1'b0;
            sda_low_ff <= 1'b0;
            pend_ff <= 1'b0;
        end else if (state_ff != eep_pkg::EEP_IDLE) begin
            if (scl_rise) begin
                if (ack_ff) begin
                    mack_ff <= ~sda_s;
                end else begin
                    shift_ff <= {shift_ff[6:0], sda_s};
                    bit_cnt_ff <= bit_cnt_ff + 4'h1;
                end
            end else if (scl_fall && ack_ff) begin
                ack_ff <= 1'b0;
                bit_cnt_ff <= 4'h0;
                sda_low_ff <= 1'b0;
                if (state_ff == eep_pkg::EEP_RDATA) begin
                    if (mack_ff) begin
                        tx_ff <= rd_byte;
                        sda_low_ff <= ~rd_byte[7];
                        addr_ff <= addr_ff + 13'h0001;
                    end else begin
                        state_ff <= eep_pkg::EEP_WAIT_STOP;
                    end
                end
            end else if (byte_end) begin
                case (state_ff)
                    eep_pkg::EEP_DEVADDR: begin
                        if (dev_match) begin
                            ack_ff <= 1'b1;
                            sda_low_ff <= 1'b1;
                            mack_ff <= 1'b1;
                            if (shift_ff[0]) begin
                                state_ff <= eep_pkg::EEP_RDATA;
                            end else begin
                                state_ff <= eep_pkg::EEP_ADDR_HI;
                            end
                        end else begin
                            state_ff <= eep_pkg::EEP_IDLE;
                        end
                    end
                    eep_pkg::EEP_ADDR_HI: begin
                        addr_ff[12:8] <= shift_ff[`EEP_HI_ADDR_W-1:0];
                        ack_ff <= 1'b1;
                        sda_low_ff <= 1'b1;
                        state_ff <= eep_pkg::EEP_ADDR_LO;
                    end
                    eep_pkg::EEP_ADDR_LO: begin
                        addr_ff[7:0] <= shift_ff;
                        ack_ff <= 1'b1;
                        sda_low_ff <= 1'b1;
                        state_ff <= eep_pkg::EEP_WDATA;
                    end
                    eep_pkg::EEP_WDATA: begin
                        if (prot_hit) begin
                            state_ff <= eep_pkg::EEP_WAIT_STOP;
                        end else begin
                            ack_ff <= 1'b1;
                            sda_low_ff <= 1'b1;
                            pend_ff <= 1'b1;
                            addr_ff <= {addr_ff[12:6],
                                        addr_ff[5:0] + 6'h01};
                        end
                    end
                    eep_pkg::EEP_RDATA: begin
                        ack_ff <= 1'b1;
                        sda_low_ff <= 1'b0;
                    end
                    default: begin
                        state_ff <= state_ff;
                    end
                endcase
            end else if (scl_fall && state_ff == eep_pkg::EEP_RDATA) begin
                sda_low_ff <= ~tx_ff[6];
                tx_ff <= {tx_ff[6:0], 1'b0};
            end
        end
    end

    // ****************************************
    // Page buffer and array programming
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buf_vld_ff <= 64'h0000_0000_0000_0000;
            page_ff <= 7'h00;
        end else if (wr_open) begin
            buf_vld_ff <= 64'h0000_0000_0000_0000;
        end else if (byte_ok) begin
            buf_vld_ff[addr_ff[5:0]] <= 1'b1;
            page_ff <= addr_ff[12:6];
        end
    end

    always_ff @(posedge clk) begin
        if (byte_ok) begin
            page_buf[addr_ff[5:0]] <= shift_ff;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            commit_ff <= 7'h40;
        end else if (prog_go) begin
            commit_ff <= 7'h00;
        end else if (busy_ff && !commit_ff[6]) begin
            commit_ff <= commit_ff + 7'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (busy_ff && !commit_ff[6] && buf_vld_ff[commit_ff[5:0]]) begin
            mem[{page_ff, commit_ff[5:0]}] <= page_buf[commit_ff[5:0]];
        end
    end

    // ****************************************
    // Write cycle timer
    // ****************************************
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_ff <= 1'b0;
            timer_ff <= 20'h0_0000;
        end else if (prog_go) begin
            busy_ff <= 1'b1;
            timer_ff <= 20'(WR_CYCLES - 1);
        end else if (busy_ff) begin
            if (timer_ff == 20'h0_0000) begin
                busy_ff <= 1'b0;
            end else begin
                timer_ff <= timer_ff - 20'h0_0001;
            end
        end
    end

    assign sda_out = 1'b0;
    assign sda_oe = sda_low_ff;
    assign busy = busy_ff;

    // ****************************************
    // Checks
    // ****************************************
    logic [19:0] busy_len_ff;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            busy_len_ff <= 20'h0_0000;
        end else begin
            busy_len_ff <= busy_ff ? busy_len_ff + 20'h0_0001 : 20'h0_0000;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_wr_byte;
        byte_end && state_ff == eep_pkg::EEP_WDATA && !prot_hit;
    endsequence

    sequence s_ack_held;
        sda_oe && ack_ff;
    endsequence

    a_od_pin: assert property (sda_out == 1'b0)
        else $error("SDA output driven high");

    a_busy_quiet: assert property (busy_ff |-> !sda_oe)
        else $error("SDA pulled low during write cycle");

    a_busy_length: assert property (
        $fell(busy_ff) |-> busy_len_ff == 20'(WR_CYCLES))
        else $error("Write cycle length wrong");

    a_start_arms: assert property (
        start_ev && !busy_ff && pwr_ok_ff |=> state_ff == eep_pkg::EEP_DEVADDR)
        else $error("START did not arm address phase");

    a_busy_ignore: assert property (
        start_ev && busy_ff |=> state_ff == eep_pkg::EEP_IDLE ##1 !sda_oe)
        else $error("Address answered while busy");

    a_stop_idle: assert property (stop_ev |=> state_ff == eep_pkg::EEP_IDLE &&
        !sda_oe)
        else $error("STOP did not end transfer");

    a_prog_start: assert property (prog_go |=> busy_ff ##1 busy_ff)
        else $error("Programming did not start at STOP");

    a_addr_nack: assert property (
        byte_end && state_ff == eep_pkg::EEP_DEVADDR && !dev_match
        |=> !sda_oe && state_ff == eep_pkg::EEP_IDLE)
        else $error("Mismatched address acknowledged");

    a_write_ack: assert property (s_wr_byte |=> s_ack_held)
        else $error("Write data byte not acknowledged");

    a_page_wrap: assert property (s_wr_byte |=>
        addr_ff[12:6] == $past(addr_ff[12:6]) &&
        addr_ff[5:0] == $past(addr_ff[5:0]) + 6'h01)
        else $error("Page address counter wrong");

    a_protect_nack: assert property (
        byte_end && state_ff == eep_pkg::EEP_WDATA && prot_hit
        |=> !sda_oe && state_ff == eep_pkg::EEP_WAIT_STOP && !byte_ok)
        else $error("Protected byte acknowledged");

    a_read_end: assert property (
        scl_fall && ack_ff && state_ff == eep_pkg::EEP_RDATA && !mack_ff
        && !start_ev && !stop_ev |=> state_ff == eep_pkg::EEP_WAIT_STOP)
        else $error("Read did not stop on missing acknowledge");

endmodule

// File: verilog/eep_consts.svh
`ifndef EEP_CONSTS_SVH
`define EEP_CONSTS_SVH

// ****************************************
// Timing
// ****************************************
`define EEP_CLK_MHZ 200
`define EEP_WR_TIME_MS 5
`define EEP_PU_TIME_MS 1
`define EEP_WR_CYCLES (`EEP_WR_TIME_MS * 1000 * `EEP_CLK_MHZ)
`define EEP_PU_CYCLES (`EEP_PU_TIME_MS * 1000 * `EEP_CLK_MHZ)

// ****************************************
// Addressing
// ****************************************
`define EEP_DEV_CODE 4'ha
`define EEP_ADDR_W 13
`define EEP_PAGE_W 6
`define EEP_PAGE_BYTES 64
`define EEP_MEM_BYTES 8192
`define EEP_HI_ADDR_W 5

`endif

// File: verilog/eep_pkg.sv
package eep_pkg;

    typedef enum logic [2:0] {
        EEP_IDLE      = 3'b000,
        EEP_DEVADDR   = 3'b001,
        EEP_ADDR_HI   = 3'b010,
        EEP_ADDR_LO   = 3'b011,
        EEP_WDATA     = 3'b100,
        EEP_RDATA     = 3'b101,
        EEP_WAIT_STOP = 3'b110
    } eep_state_t;

    typedef enum logic [1:0] {
        EEP_PROT_LOW_QTR  = 2'b00,
        EEP_PROT_HIGH_QTR = 2'b01,
        EEP_PROT_ALL      = 2'b10
    } eep_prot_t;

endpackage

// File: verilog/eep_sync.sv
`timescale 1ns/1ps

module eep_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);

    logic [W-1:0] meta_ff;

    // ****************************************
    // Two-stage synchroniser per bit
    // ****************************************
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always_ff @(posedge clk or negedge nrst) begin
                if (!nrst) begin
                    meta_ff[i] <= 1'b0;
                    dout[i] <= 1'b0;
                end else begin
                    meta_ff[i] <= din[i];
                    dout[i] <= meta_ff[i];
                end
            end
        end
    endgenerate

endmodule

// File: verification/eep_master_model.sv
`timescale 1ns/1ps

module eep_master_model (
    input wire logic clk,
    input wire logic sda_wire,
    output logic scl,
    output logic sda_oe
);
    // ****************************************
    // Bus idle
    // ****************************************
    initial begin
        scl = 1'b1;
        sda_oe = 1'b0;
    end

    task automatic gap(input int n);
        repeat (n) @(negedge clk);
    endtask

    // ****************************************
    // Conditions and bits
    // ****************************************
    // Only pulls low or releases; the pull-up gives the high level
    task automatic start();
        sda_oe = 1'b0;
        gap(6);
        scl = 1'b1;
        gap(6);
        sda_oe = 1'b1;
        gap(6);
        scl = 1'b0;
        gap(7);
    endtask

    task automatic stop();
        sda_oe = 1'b1;
        gap(6);
        scl = 1'b1;
        gap(6);
        sda_oe = 1'b0;
        gap(12);
    endtask

    // Data changes only while the clock is low
    task automatic xfer_bit(input logic b, output logic r);
        sda_oe = ~b;
        gap(7);
        scl = 1'b1;
        gap(6);
        r = sda_wire;
        gap(6);
        scl = 1'b0;
        gap(6);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(b[i], r);
        end
        xfer_bit(1'b1, r);
        ack = (r === 1'b0);
    endtask

    task automatic recv_byte(input logic more, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(~more, r);
    endtask
endmodule

// File: verification/testbench.sv
`timescale 1ns/1ps

module testbench;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wp = 1'b0;
    logic [2:0] sel = 3'h5;
    logic scl;
    logic m_oe;
    logic d_oe;
    logic d_out;
    logic busy;
    logic d2_oe;
    logic d2_out;
    logic busy2;
    wire sda_w = ~(m_oe | d_oe | d2_oe);
    int fail_count = 0;
    int checks_done = 0;
    int busy_cnt = 0;

    always #2.5 clk = ~clk;

    eep_master_model master (.clk(clk), .sda_wire(sda_w), .scl(scl),
        .sda_oe(m_oe));

    eep_slave #(.WR_CYCLES(2000), .PU_CYCLES(50)) dut (.clk(clk),
        .nrst(nrst), .scl(scl), .sda_in(sda_w), .sda_out(d_out),
        .sda_oe(d_oe), .write_protect(wp), .device_select_bit0(sel[0]),
        .device_select_bit1(sel[1]), .device_select_bit2(sel[2]),
        .busy(busy));

    // Second target on the same bus, strapped to 3, whole array protected
    eep_slave #(.WR_CYCLES(2000), .PU_CYCLES(50),
        .PROT_MODE(eep_pkg::EEP_PROT_ALL)) dut_all (.clk(clk),
        .nrst(nrst), .scl(scl), .sda_in(sda_w), .sda_out(d2_out),
        .sda_oe(d2_oe), .write_protect(wp), .device_select_bit0(1'b1),
        .device_select_bit1(1'b1), .device_select_bit2(1'b0),
        .busy(busy2));

    // ****************************************
    // Monitors
    // ****************************************
    always @(posedge clk) begin
        if (busy === 1'b1) busy_cnt++;
        if (d_oe === 1'b1 && d_out !== 1'b0) begin
            $display("wrong value sda_out expected 0 seen %b", d_out);
            fail_count++;
        end
        if (d2_oe === 1'b1 && d2_out !== 1'b0) begin
            $display("wrong value sda_out2 expected 0 seen %b", d2_out);
            fail_count++;
        end
    end

    // ****************************************
    // Checks and bus tasks
    // ****************************************
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(string name, logic [15:0] exp, logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask

    task automatic send(logic [7:0] b, logic exp);
        logic ak;
        master.send_byte(b, ak);
        chk("ack", {15'h0000, exp}, {15'h0000, ak});
    endtask

    task automatic hdr(logic [12:0] a);
        master.start();
        send({4'ha, sel, 1'b0}, 1'b1);
        send({3'h0, a[12:8]}, 1'b1);
        send(a[7:0], 1'b1);
    endtask

    task automatic rd(logic [12:0] a, logic [7:0] e0, logic [7:0] e1,
                      logic two);
        logic [7:0] d;
        hdr(a);
        master.start();
        send({4'ha, sel, 1'b1}, 1'b1);
        master.recv_byte(two, d);
        chk("read0", {8'h00, e0}, {8'h00, d});
        if (two) begin
            master.recv_byte(1'b0, d);
            chk("read1", {8'h00, e1}, {8'h00, d});
        end
        master.stop();
    endtask

    task automatic poll(logic exp);
        master.start();
        send({4'ha, sel, 1'b0}, exp);
        master.stop();
    endtask

    task automatic wait_done();
        int n;
        n = 0;
        chk("busy", 16'h0001, {15'h0000, busy});
        poll(1'b0);
        while (busy !== 1'b0 && n < 5000) begin
            @(negedge clk);
            n++;
        end
        chk("busy_len", 16'h07d0, busy_cnt[15:0]);
        poll(1'b1);
        busy_cnt = 0;
    endtask

    // ****************************************
    // Tests
    // ****************************************
    initial begin
        logic [7:0] pg [4];
        logic ak;
        pg = '{8'h11, 8'h22, 8'h33, 8'h44};
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        poll(1'b0);
        for (int i = 0; i < 8; i++) begin
            master.start();
            send({4'ha, i[2:0], 1'b0}, i[2:0] == sel || i == 3);
            master.stop();
        end
        sel = 3'h0;
        poll(1'b1);
        master.start();
        send({4'hb, sel, 1'b0}, 1'b0);
        master.stop();
        sel = 3'h5;
        hdr(13'h1000);
        send(8'ha5, 1'b1);
        master.stop();
        wait_done();
        hdr(13'h107e);
        for (int i = 0; i < 4; i++) begin
            send(pg[i], 1'b1);
        end
        master.stop();
        wait_done();
        rd(13'h1000, 8'ha5, 8'h00, 1'b0);
        rd(13'h107f, 8'h22, 8'h00, 1'b0);
        rd(13'h1040, 8'h33, 8'h44, 1'b1);
        hdr(13'h0010);
        send(8'h3c, 1'b1);
        master.stop();
        wait_done();
        wp = 1'b1;
        hdr(13'h0010);
        send(8'hc3, 1'b0);
        master.stop();
        chk("busy_wp", 16'h0000, {15'h0000, busy});
        rd(13'h0010, 8'h3c, 8'h00, 1'b0);
        master.start();
        send({4'ha, 3'h3, 1'b0}, 1'b1);
        send(8'h18, 1'b1);
        send(8'h00, 1'b1);
        send(8'h77, 1'b0);
        master.stop();
        chk("busy_all", 16'h0000, {15'h0000, busy2});
        hdr(13'h1800);
        send(8'h5a, 1'b1);
        master.stop();
        wp = 1'b0;
        wait_done();
        hdr(13'h1000);
        for (int i = 0; i < 4; i++) begin
            master.xfer_bit(i[0], ak);
        end
        master.stop();
        chk("busy_abort", 16'h0000, {15'h0000, busy});
        rd(13'h1000, 8'ha5, 8'h00, 1'b0);
        rd(13'h1800, 8'h5a, 8'h00, 1'b0);
        end_sim();
    end

    initial begin
        repeat (60000) @(posedge clk);
        fail_count++;
        end_sim();
    end
endmodule
